// ### bench/tb.sv
// Purpose: self-checking bench for the feature control block
// Assumes: read data one cycle after the read strobe
// Notes: far side is the ufc_peer model
`timescale 1ns/1ns
`include "ufc_defines.vh"
module tb;
   reg clk = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, tx_fifo_push = 1'b0;
   reg rx_char_valid = 1'b0, rx_at_trigger = 1'b0, rx_above_upper = 1'b0, st;
   reg rx_below_lower = 1'b0, hold_off = 1'b0, idle_lvl = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00, rx_char = 8'h00;
   reg [5:0] rx_level = 6'h05, tx_level = 6'h09;
   wire [7:0] rdata, tx_div_low, tx_div_high, rx_div_low, rx_div_high;
   wire [5:0] tx_frac, rx_frac;
   wire [1:0] tx_pair_mode, rx_pair_mode;
   wire thr_empty, tsr_empty, bit_tick, rx_pin, cts_b_pin, rx_data, rts_b_pin, tx_irq;
   wire tx_start_ok, rx_store, rx_pause_hit, rx_resume_hit, special_hit, rts_trigger_irq;
   integer fail_count = 0, checks_done = 0, i, j;
   always #4 clk = ~clk;
   ufc_top dut_u (
      .clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .rx_level, .tx_level,
      .tx_fifo_push, .thr_empty, .tsr_empty, .bit_tick, .char_start(1'b0), .rx_char_valid,
      .rx_char, .rx_at_trigger, .rx_above_upper, .rx_below_lower, .rx_pin, .cts_b_pin,
      .rx_data, .rts_b_pin, .tx_irq, .tx_start_ok, .rx_store, .rx_pause_hit, .rx_resume_hit,
      .special_hit, .rts_trigger_irq, .tx_pair_mode, .rx_pair_mode, .tx_div_low,
      .tx_div_high, .tx_frac, .rx_div_low, .rx_div_high, .rx_frac
   );
   ufc_peer peer_u (
      .clk, .tx_fifo_push, .hold_off, .idle_lvl, .bit_tick, .thr_empty, .tsr_empty,
      .cts_b_pin, .rx_pin
   );
   // ----
   // Access tasks
   // ----
   task chk(input [31:0] s, input [31:0] e);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
         end
      end
   endtask
   task cy(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr_stb <= 1'b1;
         @(posedge clk);
         wr_stb <= 1'b0;
         #1;
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         @(posedge clk);
         addr <= a;
         rd_stb <= 1'b1;
         @(posedge clk);
         rd_stb <= 1'b0;
         #1;
         chk(rdata, e);
      end
   endtask
   // Received character: store decision sampled while valid is up
   task rx(input [7:0] c);
      begin
         @(posedge clk);
         rx_char <= c;
         rx_char_valid <= 1'b1;
         #1;
         st = rx_store;
         @(posedge clk);
         rx_char_valid <= 1'b0;
         #1;
      end
   endtask
   task psh;
      begin
         @(posedge clk);
         tx_fifo_push <= 1'b1;
         @(posedge clk);
         tx_fifo_push <= 1'b0;
         #1;
      end
   endtask
   // Bounded wait for the shifter to drain
   task wt;
      begin
         for (j = 0; j < 200 && !tsr_empty; j = j + 1)
            cy(1);
         if (!tsr_empty) begin
            fail_count = fail_count + 1;
            $display("unexpected at %0t: shifter never drained", $time);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, fail_count);
         if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      fail_count = fail_count + 1;
      end_of_test;
   end
   // ----
   // Tests
   // ----
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      rd(`UFC_A_SCRATCH, `UFC_SCR_RST);
      rd(`UFC_A_ENH, 8'h00);
      rd(`UFC_A_IER, 8'h00);
      wr(`UFC_A_IER, 8'hff);
      rd(`UFC_A_IER, 8'h0f);
      wr(`UFC_A_FRAC, 8'h41);
      rd(`UFC_A_FRAC, 8'h00);
      wr(`UFC_A_ENH, 8'h10);
      wr(`UFC_A_IER, 8'hf2);
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_IER, 8'h02);
      rd(`UFC_A_IER, 8'hf2);
      wr(`UFC_A_ENH, 8'h10);
      wr(`UFC_A_FRAC, 8'h00);
      wr(`UFC_A_DIV_LOW, 8'h55);
      chk({tx_div_low, rx_div_low}, 16'h5555);
      wr(`UFC_A_FRAC, 8'h45);
      wr(`UFC_A_DIV_LOW, 8'h66);
      wr(`UFC_A_DIV_HIGH, 8'h12);
      chk({tx_div_high, rx_div_high}, 16'h1200);
      wr(`UFC_A_FRAC, 8'hc0);
      wr(`UFC_A_DIV_LOW, 8'h77);
      wr(`UFC_A_FRAC, 8'h87);
      wr(`UFC_A_DIV_LOW, 8'h99);
      chk({tx_div_low, rx_div_low, 2'b00, tx_frac, 2'b00, rx_frac}, 32'h66770500);
      wr(`UFC_A_FEAT, 8'h04);
      cy(3);
      chk(rx_data, 1'b1);
      @(posedge clk);
      idle_lvl <= 1'b1;
      cy(3);
      chk(rx_data, 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         wr(`UFC_A_ENH, 8'h00);
         wr(`UFC_A_ENH, 8'h05 * i);
         chk({tx_pair_mode, rx_pair_mode}, 4'h5 * i);
      end
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_ENH, 8'h80);
      @(posedge clk);
      hold_off <= 1'b1;
      cy(3);
      chk(tx_start_ok, 1'b0);
      @(posedge clk);
      hold_off <= 1'b0;
      cy(3);
      chk(tx_start_ok, 1'b1);
      wr(`UFC_A_PAU2, 8'ha5);
      wr(`UFC_A_ENH, 8'h30);
      wr(`UFC_A_IER, 8'h22);
      rx(8'ha5);
      chk({st, special_hit, rx_pause_hit}, 3'b110);
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_ENH, 8'h31);
      rx(8'ha5);
      chk({st, special_hit, rx_pause_hit}, 3'b011);
      wr(`UFC_A_RES1, 8'h11);
      wr(`UFC_A_RES2, 8'h22);
      wr(`UFC_A_PAU1, 8'h33);
      wr(`UFC_A_PAU2, 8'h44);
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_ENH, 8'h0b);
      for (i = 0; i < 4; i = i + 1) begin
         rx(8'h11 * (i + 1));
         chk({rx_resume_hit, rx_pause_hit}, (i < 2) ? 2'b10 : 2'b01);
      end
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_ENH, 8'h0f);
      rx(8'h33);
      rx(8'h44);
      chk({rx_resume_hit, rx_pause_hit}, 2'b01);
      rx(8'h11);
      rx(8'h22);
      chk({rx_resume_hit, rx_pause_hit}, 2'b10);
      rx(8'h44);
      chk({rx_resume_hit, rx_pause_hit}, 2'b00);
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_MCR, 8'h02);
      wr(`UFC_A_ENH, 8'h40);
      @(posedge clk);
      rx_at_trigger <= 1'b1;
      rx_above_upper <= 1'b1;
      cy(2);
      chk({rts_trigger_irq, rts_b_pin}, 2'b11);
      @(posedge clk);
      rx_above_upper <= 1'b0;
      rx_below_lower <= 1'b1;
      cy(2);
      chk(rts_b_pin, 1'b0);
      wr(`UFC_A_MCR, 8'h00);
      cy(2);
      chk(rts_b_pin, 1'b1);
      wr(`UFC_A_ENH, 8'h00);
      wr(`UFC_A_FEAT, 8'h08);
      psh;
      cy(1);
      chk(rts_b_pin, 1'b0);
      cy(6);
      chk({thr_empty, tsr_empty, tx_irq}, 3'b100);
      wt;
      chk(rts_b_pin, 1'b0);
      cy(12);
      chk({rts_b_pin, tx_irq}, 2'b11);
      wr(`UFC_A_FEAT, 8'h00);
      psh;
      cy(6);
      chk({tsr_empty, tx_irq}, 2'b01);
      wt;
      wr(`UFC_A_SCRATCH, 8'h3c);
      wr(`UFC_A_FEAT, 8'h40);
      rd(`UFC_A_SCRATCH, 8'h05);
      wr(`UFC_A_FEAT, 8'hc0);
      rd(`UFC_A_SCRATCH, 8'h09);
      wr(`UFC_A_SCRATCH, 8'h08);
      wr(`UFC_A_FEAT, 8'h00);
      rd(`UFC_A_SCRATCH, 8'h3c);
      wr(`UFC_A_LCR, `UFC_LCR_KEY);
      rd(`UFC_A_SCRATCH, 8'h05);
      wr(`UFC_A_FEAT, 8'h48);
      psh;
      cy(6);
      chk(rts_b_pin, 1'b1);
      wt;
      cy(12);
      chk(rts_b_pin, 1'b0);
      end_of_test;
   end
endmodule

// ### bench/ufc_peer.sv
// Purpose: far-side model, remote station and transmit line timing
// Assumes: BIT_CLKS clocks per bit, ten bits per character
// Notes: the shifter always finishes the character it holds
`timescale 1ns/1ns
module ufc_peer #(parameter [3:0] BIT_CLKS = 4'h4) (
   input wire clk,
   input wire tx_fifo_push,
   input wire hold_off,
   input wire idle_lvl,
   output reg bit_tick = 1'b0,
   output reg thr_empty = 1'b1,
   output reg tsr_empty = 1'b1,
   output wire cts_b_pin,
   output wire rx_pin
);
   reg [3:0] div_c = 4'h1;
   reg [3:0] bits_c = 4'h0;
   // Remote pauses us by raising its clear-to-send line
   assign cts_b_pin = hold_off;
   assign rx_pin = idle_lvl;
   // ----
   // Bit clock and shifter
   // ----
   always @(posedge clk) begin
      div_c <= (div_c == BIT_CLKS) ? 4'h1 : div_c + 4'h1;
      bit_tick <= (div_c == BIT_CLKS);
      if (tx_fifo_push)
         thr_empty <= 1'b0;
      else if (bit_tick && !thr_empty && tsr_empty) begin
         thr_empty <= 1'b1;
         tsr_empty <= 1'b0;
         bits_c <= 4'ha;
      end else if (bit_tick && bits_c != 4'h0) begin
         bits_c <= bits_c - 4'h1;
         tsr_empty <= (bits_c == 4'h1);
      end
   end
endmodule

// ### bench/ufc_top_asserts.sv
// Purpose: assertions for the feature control block
// Assumes: one clock, synchronous active-low reset
// Notes: shadows only the control bits the checks depend on
`timescale 1ns/1ns
`include "ufc_defines.vh"
module ufc_chk (
   input wire clk,
   input wire rst_b,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire tx_fifo_push,
   input wire tsr_empty,
   input wire rx_char_valid,
   input wire [7:0] rx_char,
   input wire rx_pin,
   input wire cts_b_pin,
   input wire rx_data,
   input wire rts_b_pin,
   input wire tx_irq,
   input wire tx_start_ok,
   input wire rx_store,
   input wire rx_pause_hit,
   input wire [7:0] tx_div_low,
   input wire [7:0] rx_div_low
);
   reg [7:0] en_reg;
   reg [7:0] ft_reg;
   reg [7:0] p2_reg;
   reg [1:0] fr_reg;
   reg inv_reg;
   wire dl_wr = wr_stb && addr == `UFC_A_DIV_LOW;
   // ----
   // Shadows; fraction bits move only while enhanced writes are open
   // ----
   always @(posedge clk) begin
      if (!rst_b) begin
         en_reg <= 8'h00;
         ft_reg <= 8'h00;
         p2_reg <= 8'h00;
         fr_reg <= 2'b00;
         inv_reg <= 1'b0;
      end else if (wr_stb) begin
         if (addr == `UFC_A_ENH)
            en_reg <= wdata;
         if (addr == `UFC_A_FEAT)
            ft_reg <= wdata;
         if (addr == `UFC_A_PAU2)
            p2_reg <= wdata;
         if (addr == `UFC_A_FRAC && en_reg[4])
            fr_reg <= wdata[7:6];
         if (addr == `UFC_A_SCRATCH && ft_reg[6])
            inv_reg <= wdata[3];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // ----
   // Properties
   // ----
   a_div_discard: assert property (
      dl_wr && fr_reg == 2'b10 |=> $stable(tx_div_low) && $stable(rx_div_low))
      else $error("discarded divisor write landed");
   a_div_tx: assert property (
      dl_wr && fr_reg == 2'b01 |=> tx_div_low == $past(wdata) && $stable(rx_div_low))
      else $error("transmit divisor misrouted");
   a_div_rx: assert property (
      dl_wr && fr_reg == 2'b11 |=> rx_div_low == $past(wdata) && $stable(tx_div_low))
      else $error("receive divisor misrouted");
   a_irda_sense: assert property (
      $past(rst_b) && $past(rst_b, 2) |-> rx_data == ($past(rx_pin, 2) ^ ft_reg[2]))
      else $error("receive sense wrong");
   a_cts_halt: assert property (
      $past(en_reg[7]) && $past(cts_b_pin, 3) && $past(rst_b) && $past(rst_b, 3)
      |-> !tx_start_ok)
      else $error("transmitter not halted");
   a_spec_drop: assert property (
      rx_char_valid && en_reg[5] && en_reg[1:0] == 2'b01 && rx_char == p2_reg
      |-> !rx_store ##1 rx_pause_hit)
      else $error("pause character not dropped");
   a_irq_hold: assert property (
      ft_reg[3] && !tsr_empty |-> !tx_irq)
      else $error("early transmit interrupt");
   a_dir_low: assert property (
      ft_reg[3] && tx_fifo_push |-> ##2 rts_b_pin == inv_reg)
      else $error("direction pin not in transmit state");
   c_rx_route: cover property (dl_wr && fr_reg == 2'b11);
   c_drop: cover property (rx_char_valid && !rx_store);
   c_halt: cover property (en_reg[7] && !tx_start_ok);
endmodule
bind ufc_top ufc_chk chk_u (
   .clk, .rst_b, .addr, .wdata, .wr_stb, .tx_fifo_push, .tsr_empty, .rx_char_valid,
   .rx_char, .rx_pin, .cts_b_pin, .rx_data, .rts_b_pin, .tx_irq, .tx_start_ok,
   .rx_store, .rx_pause_hit, .tx_div_low, .rx_div_low
);

// ### hdl/ufc_defines.vh
// Purpose: constants for the enhanced feature control block
// Assumes: 8-bit register port, 4-bit word index
// Notes: register indices are local choices
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define UFC_A_DIV_LOW 4'h0
`define UFC_A_DIV_HIGH 4'h1
`define UFC_A_FRAC 4'h2
`define UFC_A_IER 4'h3
`define UFC_A_ISR 4'h4
`define UFC_A_FCR 4'h5
`define UFC_A_LCR 4'h6
`define UFC_A_MCR 4'h7
`define UFC_A_SCRATCH 4'h8
`define UFC_A_FEAT 4'h9
`define UFC_A_ENH 4'ha
`define UFC_A_RES1 4'hb
`define UFC_A_RES2 4'hc
`define UFC_A_PAU1 4'hd
`define UFC_A_PAU2 4'he
`define UFC_A_STAT 4'hf
// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define UFC_FR_SEL 7
`define UFC_FR_IND 6
`define UFC_FR_LOW 5:0
`define UFC_FT_IRINV 2
`define UFC_FT_485 3
`define UFC_FT_SWAP 6
`define UFC_FT_TXCNT 7
`define UFC_EF_SWTX 3:2
`define UFC_EF_SWRX 1:0
`define UFC_EF_ENH 4
`define UFC_EF_SPEC 5
`define UFC_EF_ARTS 6
`define UFC_EF_ACTS 7
`define UFC_EM_INV 3
`define UFC_MC_RTS 1
`define UFC_LCR_KEY 8'hbf
`define UFC_SCR_RST 8'hff
`define UFC_ZERO8 8'h00
`define UFC_ZERO6 6'h00
`define UFC_DIV_RST 8'h01
`define UFC_IER_ENH 8'hf0
`define UFC_ISR_ENH 8'h30
`define UFC_FCR_ENH 8'h38
`define UFC_MCR_ENH 8'he0
`define UFC_FRAC_W 6'h3f
`define UFC_RX_PAIR2 2'b01
`define UFC_RX_BOTH 2'b11
`endif

// ### hdl/ufc_top.v
// Purpose: enhanced feature control of a 16550-style UART
// Assumes: one clock, synchronous active-low reset, FIFOs and shifter outside
// Notes: line pins pass two flops before use
//
// What this block does
// - Enable bit 0 shares one generator; 1 gives separate generators.
// - Select and enable route divisor writes to both, transmit or receive.
// - Select 1 with enable 0 discards divisor and fraction writes.
// - Scratchpad reads return level count when swapped or line control is 0xbf.
// - Level count shows receive FIFO when select 0, transmit when 1.
// - Inversion bit selects idle-low or idle-high infrared receive input.
// - Direction control off: transmit interrupt when holding register empties.
// - Direction control on: pin goes high one bit after last stop bit.
// - Direction control on: transmit interrupt waits for empty shifter.
// - Direction control on: pin returns low when a byte enters transmit FIFO.
// - Invert bit flips direction pin polarity.
// - Swap bit 0 plain scratchpad; 1 reads count, writes enhanced mode.
// - Flow control bits pick first, second or both pairs per direction.
// - Single transmit pair with both compare bits accepts either character.
// - Enhanced enable gates writes to enhanced fields; cleared means hold.
// - Enhanced fields read zero after reset.
// - Special detect compares with second pause char; match stored, flags.
// - Special detect with second pair: match dropped, pause and special flags.
// - Auto request flag at trigger, pin high at upper, low below lower.
// - Auto request acts only after host asserts pin low; else plain output.
// - Auto clear-to-send stops transmitter high, resumes low.
// - Character in flight finishes before halting.
`timescale 1ns/1ns
`include "ufc_defines.vh"
module ufc_top (
   input wire clk,
   input wire rst_b,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr_stb,
   input wire rd_stb,
   output reg [7:0] rdata,
   input wire [5:0] rx_level,
   input wire [5:0] tx_level,
   input wire tx_fifo_push,
   input wire thr_empty,
   input wire tsr_empty,
   input wire bit_tick,
   input wire char_start,
   input wire rx_char_valid,
   input wire [7:0] rx_char,
   input wire rx_at_trigger,
   input wire rx_above_upper,
   input wire rx_below_lower,
   input wire rx_pin,
   input wire cts_b_pin,
   output wire rx_data,
   output reg rts_b_pin,
   output wire tx_irq,
   output wire tx_start_ok,
   output wire rx_store,
   output reg rx_pause_hit,
   output reg rx_resume_hit,
   output reg special_hit,
   output reg rts_trigger_irq,
   output wire [1:0] tx_pair_mode,
   output wire [1:0] rx_pair_mode,
   output reg [7:0] tx_div_low,
   output reg [7:0] tx_div_high,
   output reg [5:0] tx_frac,
   output reg [7:0] rx_div_low,
   output reg [7:0] rx_div_high,
   output reg [5:0] rx_frac
);
   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg [7:0] frac_reg;
   reg [7:0] ier_reg;
   reg [7:0] isr_reg;
   reg [7:0] fcr_reg;
   reg [7:0] lcr_reg;
   reg [7:0] mcr_reg;
   reg [7:0] scr_reg;
   reg [7:0] feat_reg;
   reg [7:0] enh_reg;
   reg [7:0] enhanced_mode_select_reg;
   reg [7:0] res1_reg;
   reg [7:0] res2_reg;
   reg [7:0] pau1_reg;
   reg [7:0] pau2_reg;
   reg [1:0] rx_sync_reg;
   reg [1:0] cts_sync_reg;
   reg dir_tx_reg;
   reg dir_wait_reg;
   reg pend_reg;
   reg cts_stop_reg;
   reg [1:0] rx_seq_reg;

   // ----------------------------------------
   // Decoded controls
   // ----------------------------------------
   // Every write is taken in its strobe cycle; no wait states
   wire wr_any = wr_stb;
   wire enh_on = enh_reg[`UFC_EF_ENH];
   wire auto485 = feat_reg[`UFC_FT_485];
   wire swap = feat_reg[`UFC_FT_SWAP];
   wire frac_sel = frac_reg[`UFC_FR_SEL];
   wire frac_ind = frac_reg[`UFC_FR_IND];
   wire [7:0] level_count = feat_reg[`UFC_FT_TXCNT] ? {2'b00, tx_level} :
      {2'b00, rx_level};
   // Divisor write routing from current select/enable bits
   // Select set with enable clear routes nowhere, so both generators keep
   // their divisors; the routing stays until the fraction byte changes
   wire route_tx = ~frac_sel;
   wire route_rx = (~frac_sel & ~frac_ind) | (frac_sel & frac_ind);
   wire w_div_low = wr_any & (addr == `UFC_A_DIV_LOW);
   wire w_div_high = wr_any & (addr == `UFC_A_DIV_HIGH);
   wire w_frac = wr_any & (addr == `UFC_A_FRAC) & enh_on;
   // Fraction byte's own select/enable decide its routing
   // Trade-off: new select bits steer their own fraction field in one write
   wire wf_sel = wdata[`UFC_FR_SEL];
   wire wf_ind = wdata[`UFC_FR_IND];
   wire wf_tx = ~wf_sel;
   wire wf_rx = (~wf_sel & ~wf_ind) | (wf_sel & wf_ind);
   // Guarded merge: only enhanced bits need the enable
   // Legacy bits always follow the write so old drivers keep working
   function [7:0] guard;
      input [7:0] old_v;
      input [7:0] new_v;
      input [7:0] mask;
      input en;
      begin
         guard = en ? new_v : ((new_v & ~mask) | (old_v & mask));
      end
   endfunction

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   // Enhanced fields clear on reset for legacy behaviour
   // Line control and feature bits are writable at any time
   always @(posedge clk) begin
      if (!rst_b) begin
         frac_reg <= `UFC_ZERO8;
         ier_reg <= `UFC_ZERO8;
         isr_reg <= `UFC_ZERO8;
         fcr_reg <= `UFC_ZERO8;
         lcr_reg <= `UFC_ZERO8;
         mcr_reg <= `UFC_ZERO8;
         scr_reg <= `UFC_SCR_RST;
         feat_reg <= `UFC_ZERO8;
         enh_reg <= `UFC_ZERO8;
         enhanced_mode_select_reg <= `UFC_ZERO8;
         res1_reg <= `UFC_ZERO8;
         res2_reg <= `UFC_ZERO8;
         pau1_reg <= `UFC_ZERO8;
         pau2_reg <= `UFC_ZERO8;
      end else if (wr_any) begin
         case (addr)
            `UFC_A_FRAC: if (enh_on) frac_reg <= wdata;
            `UFC_A_IER: ier_reg <= guard(ier_reg, wdata, `UFC_IER_ENH, enh_on);
            `UFC_A_ISR: isr_reg <= guard(isr_reg, wdata, `UFC_ISR_ENH, enh_on);
            `UFC_A_FCR: fcr_reg <= guard(fcr_reg, wdata, `UFC_FCR_ENH, enh_on);
            `UFC_A_LCR: lcr_reg <= wdata;
            `UFC_A_MCR: mcr_reg <= guard(mcr_reg, wdata, `UFC_MCR_ENH, enh_on);
            `UFC_A_SCRATCH: begin
               if (swap) begin
                  enhanced_mode_select_reg <= wdata;
               end else begin
                  scr_reg <= wdata;
               end
            end
            `UFC_A_FEAT: feat_reg <= wdata;
            `UFC_A_ENH: enh_reg <= wdata;
            `UFC_A_RES1: res1_reg <= wdata;
            `UFC_A_RES2: res2_reg <= wdata;
            `UFC_A_PAU1: pau1_reg <= wdata;
            `UFC_A_PAU2: pau2_reg <= wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Baud generator divisors
   // ----------------------------------------
   // Divisors reset to low byte 0x01, high byte 0x00 with the rest
   // Limitation: rst_b also restores them, so software must reprogram
   always @(posedge clk) begin
      if (!rst_b) begin
         tx_div_low <= `UFC_DIV_RST;
         rx_div_low <= `UFC_DIV_RST;
         tx_div_high <= `UFC_ZERO8;
         rx_div_high <= `UFC_ZERO8;
         tx_frac <= `UFC_ZERO6;
         rx_frac <= `UFC_ZERO6;
      end else begin
         if (w_div_low & route_tx) tx_div_low <= wdata;
         if (w_div_low & route_rx) rx_div_low <= wdata;
         if (w_div_high & route_tx) tx_div_high <= wdata;
         if (w_div_high & route_rx) rx_div_high <= wdata;
         if (w_frac & wf_tx) tx_frac <= wdata[`UFC_FR_LOW] & `UFC_FRAC_W;
         if (w_frac & wf_rx) rx_frac <= wdata[`UFC_FR_LOW] & `UFC_FRAC_W;
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Data one cycle after the strobe; unmapped returns zero
   // Divisor reads follow the select bit so either set can be read back
   always @(posedge clk) begin
      if (!rst_b) begin
         rdata <= `UFC_ZERO8;
      end else if (rd_stb) begin
         case (addr)
            `UFC_A_DIV_LOW: rdata <= frac_sel ? rx_div_low : tx_div_low;
            `UFC_A_DIV_HIGH: rdata <= frac_sel ? rx_div_high : tx_div_high;
            `UFC_A_FRAC: rdata <= frac_reg;
            `UFC_A_IER: rdata <= ier_reg;
            `UFC_A_ISR: rdata <= isr_reg;
            `UFC_A_FCR: rdata <= fcr_reg;
            `UFC_A_LCR: rdata <= lcr_reg;
            `UFC_A_MCR: rdata <= mcr_reg;
            `UFC_A_SCRATCH: rdata <= (swap | (lcr_reg == `UFC_LCR_KEY)) ?
               level_count : scr_reg;
            `UFC_A_FEAT: rdata <= feat_reg;
            `UFC_A_ENH: rdata <= enh_reg;
            `UFC_A_RES1: rdata <= res1_reg;
            `UFC_A_RES2: rdata <= res2_reg;
            `UFC_A_PAU1: rdata <= pau1_reg;
            `UFC_A_PAU2: rdata <= pau2_reg;
            `UFC_A_STAT: rdata <= {4'h0, cts_stop_reg, dir_tx_reg, rx_seq_reg};
            default: rdata <= `UFC_ZERO8;
         endcase
      end
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Two flops per pin against metastability; only the second is read
   // Clear-to-send resets to its stop level, the safe side
   always @(posedge clk) begin
      if (!rst_b) begin
         rx_sync_reg <= 2'b00;
         cts_sync_reg <= 2'b11;
      end else begin
         rx_sync_reg <= {rx_sync_reg[0], rx_pin};
         cts_sync_reg <= {cts_sync_reg[0], cts_b_pin};
      end
   end
   assign rx_data = rx_sync_reg[1] ^ feat_reg[`UFC_FT_IRINV];

   // ----------------------------------------
   // Direction control and transmit interrupt
   // ----------------------------------------
   // dir_tx high means transmitting; waits one bit after shifter empties
   // First tick after drain arms the wait, the next drops the direction
   // A push wins over the drain so a new byte never loses the line
   always @(posedge clk) begin
      if (!rst_b) begin
         dir_tx_reg <= 1'b0;
         dir_wait_reg <= 1'b0;
      end else if (tx_fifo_push & auto485) begin
         dir_tx_reg <= 1'b1;
         dir_wait_reg <= 1'b0;
      end else if (dir_tx_reg & tsr_empty & thr_empty & bit_tick) begin
         if (dir_wait_reg) begin
            dir_tx_reg <= 1'b0;
            dir_wait_reg <= 1'b0;
         end else begin
            dir_wait_reg <= 1'b1;
         end
      end
   end
   assign tx_irq = auto485 ? (thr_empty & tsr_empty) : thr_empty;

   // ----------------------------------------
   // Request-to-send pin
   // ----------------------------------------
   // Pin level: 485 mode, auto request, or plain output (active low)
   // Auto request keeps its level between the two hysteresis marks
   wire dir_level = dir_tx_reg ^ ~enhanced_mode_select_reg[`UFC_EM_INV];
   wire host_rts = mcr_reg[`UFC_MC_RTS];
   always @(posedge clk) begin
      if (!rst_b) begin
         rts_b_pin <= 1'b1;
         pend_reg <= 1'b0;
      end else if (auto485) begin
         rts_b_pin <= dir_level;
      end else if (enh_reg[`UFC_EF_ARTS] & host_rts) begin
         if (rx_above_upper) begin
            rts_b_pin <= 1'b1;
         end else if (rx_below_lower) begin
            rts_b_pin <= 1'b0;
         end
      end else begin
         rts_b_pin <= ~host_rts;
      end
   end

   // ----------------------------------------
   // Flow-control interrupt
   // ----------------------------------------
   // Trigger interrupt flag lasts while at trigger
   // Level, not pulse: the interrupt logic outside decides when it clears
   always @(posedge clk) begin
      if (!rst_b) begin
         rts_trigger_irq <= 1'b0;
      end else begin
         rts_trigger_irq <= enh_reg[`UFC_EF_ARTS] & rx_at_trigger;
      end
   end

   // ----------------------------------------
   // Auto clear-to-send
   // ----------------------------------------
   // Halt gates only the start of a new character
   // The shifter outside always finishes its frame, so no mid-character cut
   always @(posedge clk) begin
      if (!rst_b) begin
         cts_stop_reg <= 1'b0;
      end else begin
         cts_stop_reg <= enh_reg[`UFC_EF_ACTS] & cts_sync_reg[1];
      end
   end
   assign tx_start_ok = ~cts_stop_reg;

   // ----------------------------------------
   // Software flow and special character detect
   // ----------------------------------------
   // Modes pass straight to the flow logic outside
   assign tx_pair_mode = enh_reg[`UFC_EF_SWTX];
   assign rx_pair_mode = enh_reg[`UFC_EF_SWRX];
   // Single transmit pair with both compare bits means either character counts
   wire [1:0] rxm = enh_reg[`UFC_EF_SWRX];
   wire single_tx = ^enh_reg[`UFC_EF_SWTX];
   wire either = (rxm == `UFC_RX_BOTH) & single_tx;
   wire seq = (rxm == `UFC_RX_BOTH) & ~single_tx;
   // Every received character is compared against all four flow characters
   wire m_r1 = rx_char == res1_reg;
   wire m_r2 = rx_char == res2_reg;
   wire m_p1 = rx_char == pau1_reg;
   wire m_p2 = rx_char == pau2_reg;
   wire spec_on = enh_reg[`UFC_EF_SPEC];
   // Second pause character is swallowed only in second-pair mode
   wire drop2 = spec_on & (rxm == `UFC_RX_PAIR2) & m_p2;
   assign rx_store = rx_char_valid & ~drop2;
   // rx_seq tracks first char of a two-char sequence: bit0 resume, bit1 pause
   // Hits are one-cycle pulses after the character; no sticky flags here
   always @(posedge clk) begin
      if (!rst_b) begin
         rx_pause_hit <= 1'b0;
         rx_resume_hit <= 1'b0;
         special_hit <= 1'b0;
         rx_seq_reg <= 2'b00;
      end else begin
         rx_pause_hit <= 1'b0;
         rx_resume_hit <= 1'b0;
         special_hit <= 1'b0;
         if (rx_char_valid) begin
            rx_seq_reg <= 2'b00;
            if (seq) begin
               rx_seq_reg <= {m_p1, m_r1};
               rx_pause_hit <= rx_seq_reg[1] & m_p2;
               rx_resume_hit <= rx_seq_reg[0] & m_r2;
            end else if (either) begin
               rx_pause_hit <= m_p1 | m_p2;
               rx_resume_hit <= m_r1 | m_r2;
            end else begin
               rx_pause_hit <= (rxm[1] & ~rxm[0] & m_p1) | (rxm == `UFC_RX_PAIR2 & m_p2);
               rx_resume_hit <= (rxm[1] & ~rxm[0] & m_r1) | (rxm == `UFC_RX_PAIR2 & m_r2);
            end
            special_hit <= spec_on & m_p2 & ier_reg[`UFC_EF_SPEC];
         end
      end
   end
endmodule
